//--- rtl/epp_ecp_pkg.sv
/*
  Constants, offsets and state codes of the parallel port block.
  Assumes a 20 MHz system clock.
*/
package epp_ecp_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int EPP_TIMEOUT_NS = 10000;
  // longest wait: rounded down
  localparam int EPP_TIMEOUT_CYC = EPP_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int STROBE_MIN_NS = 500;
  // least time: rounded up
  localparam int STROBE_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // offsets from the base address
  localparam logic [15:0] OFF_DATA = 16'h0000;
  localparam logic [15:0] OFF_STATUS = 16'h0001;
  localparam logic [15:0] OFF_CONTROL = 16'h0002;
  localparam logic [15:0] OFF_EPP_ADDR = 16'h0003;
  localparam logic [15:0] OFF_EPP_DATA_LO = 16'h0004;
  localparam logic [15:0] OFF_EPP_DATA_HI = 16'h0007;
  localparam logic [15:0] OFF_FIFO = 16'h0400;
  localparam logic [15:0] OFF_CONFIG_B = 16'h0401;
  localparam logic [15:0] OFF_EXT_CTRL = 16'h0402;
  // modes in extended control bits 7-5
  localparam logic [2:0] MODE_STD = 3'h0;
  localparam logic [2:0] MODE_BIDIR = 3'h1;
  localparam logic [2:0] MODE_COMPAT_FIFO = 3'h2;
  localparam logic [2:0] MODE_EXTENDED = 3'h3;
  localparam logic [2:0] MODE_ENHANCED = 3'h4;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CONFIG = 3'h7;
  // field positions
  localparam int EXT_MODE_LSB = 5;
  localparam int EXT_ERRINT_BIT = 4;
  localparam int EXT_DMA_BIT = 3;
  localparam int EXT_SVC_BIT = 2;
  localparam int CTL_DIR_BIT = 5;
  localparam int CTL_ACKIRQ_BIT = 4;
  localparam int CTL_SELECT_BIT = 3;
  localparam int CTL_INIT_BIT = 2;
  localparam int CTL_AUTOFD_BIT = 1;
  localparam int CTL_STROBE_BIT = 0;
  localparam int STAT_TMO_BIT = 0;
  // reset values
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [5:0] CTL_RESET = 6'h04;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [7:0] CONFIG_A_VALUE = 8'h10;
  // peripheral-side sequencer
  typedef enum logic [8:0] {
    P_IDLE = 9'h001,
    P_EPPWAIT = 9'h002,
    P_EPPSTB = 9'h004,
    P_SETUP = 9'h008,
    P_STB = 9'h010,
    P_HOLD = 9'h020,
    P_RREQ = 9'h040,
    P_RLE = 9'h080,
    P_RREL = 9'h100
  } pstate_e;
endpackage

//--- rtl/port_fifo.sv
/*
  Small synchronous FIFO with registered read data.
  Assumes pop is only asserted when not empty, push when not full.
*/
`timescale 1ns/10ps
`default_nettype none
module port_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] pushData,
  input wire logic pop,
  // data and flags
  output logic [WIDTH-1:0] popData,
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic [WIDTH-1:0] popData;
  } fifo_s;

  fifo_s r;
  fifo_s n;

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_check
      $error("port_fifo: DEPTH must be a power of two");
    end
  endgenerate

  assign full = (r.count == (AW+1)'(DEPTH));
  assign empty = (r.count == '0);
  assign popData = r.popData;

  always_comb
  begin
    n = r;
    if (pop)
    begin
      n.popData = r.mem[r.rdPtr];
      n.rdPtr = r.rdPtr + 1'b1;
    end
    if (push)
    begin
      n.mem[r.wrPtr] = pushData;
      n.wrPtr = r.wrPtr + 1'b1;
    end
    n.count = r.count + (AW+1)'(push) - (AW+1)'(pop);
    // flush drops contents but keeps the last read word
    if (flush)
    begin
      n.wrPtr = '0;
      n.rdPtr = '0;
      n.count = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      r <= '0;
    else
      r <= n;
  end
endmodule
`default_nettype wire

//--- rtl/epp_ecp_parallel_port.sv
/*
  Host-side parallel port: standard, bidirectional, FIFO, extended and
  enhanced modes, with register window at a strap-set base address.
  Assumes host strobes are one-cycle pulses synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module epp_ecp_parallel_port #(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host register port
  input wire logic [15:0] baseAddress,
  input wire logic [15:0] hostAddr,
  input wire logic [7:0] hostWrData,
  input wire logic hostWr,
  input wire logic hostRd,
  output logic [7:0] hostRdData,
  output logic hostRdValid,
  output logic hostBusy,
  // dma and interrupt
  input wire logic dmaAck,
  output logic dmaReq,
  output logic ackIrq,
  // straps
  input wire logic eppEnable,
  input wire logic eppRev17,
  // peripheral inputs
  input wire logic busyIn,
  input wire logic acknowledgeInN,
  input wire logic paperOutIn,
  input wire logic selectedIn,
  input wire logic faultInN,
  input wire logic peripheralHoldN,
  // port line readback and peripheral outputs
  input wire logic [7:0] portLinesIn,
  output logic [7:0] portLinesOut,
  output logic portLinesOeN,
  output logic byteStrobeOutN,
  output logic autoLinefeedOutN,
  output logic selectRequestOutN,
  output logic peripheralReinitN
);
  localparam logic [7:0] TMO_LAST = 8'(epp_ecp_pkg::EPP_TIMEOUT_CYC - 1);
  localparam logic [7:0] STB_LAST = 8'(epp_ecp_pkg::STROBE_CYC - 1);

  typedef struct packed {
    epp_ecp_pkg::pstate_e st;
    logic [7:0] dataReg;
    logic [5:0] ctl;
    logic [2:0] mode;
    logic errIntrEn;
    logic dmaEn;
    logic svcIntr;
    logic tmo;
    logic [7:0] cnt;
    logic [7:0] outByte;
    logic outTag;
    logic isRead;
    logic isAddr;
    logic sawLow;
    logic rlePend;
    logic [7:0] rleCnt;
    logic rdStage;
    logic [2:0] rdSrc;
    logic [7:0] rdData;
    logic rdValid;
    logic ackQ;
    logic irq;
  } state_s;

  localparam state_s RESET_STATE = '{
    st: epp_ecp_pkg::P_IDLE,
    dataReg: epp_ecp_pkg::DATA_RESET,
    ctl: epp_ecp_pkg::CTL_RESET,
    mode: epp_ecp_pkg::MODE_RESET,
    errIntrEn: 1'b1,
    svcIntr: 1'b1,
    ackQ: 1'b1,
    default: '0
  };

  state_s r;
  state_s n;

  logic [15:0] offset;
  logic take;
  logic eppMode;
  logic eppStart;
  logic eppActive;
  logic dirEff;
  logic fwdEngine;
  logic revEngine;
  logic hostFifoWr;
  logic hostFifoRd;
  logic fifoPush;
  logic [8:0] fifoPushData;
  logic fifoPop;
  logic [8:0] fifoRdData;
  logic fifoFull;
  logic fifoEmpty;
  logic writeDirectionN;
  logic dataStrobeN;
  logic addrStrobeN;
  logic fwdDrive;

  generate
    if (FIFO_DEPTH != 16)
    begin : g_check
      $error("epp_ecp_parallel_port: FIFO_DEPTH must be 16");
    end
  endgenerate

  assign offset = hostAddr - baseAddress;
  assign eppActive = (r.st == epp_ecp_pkg::P_EPPWAIT) || (r.st == epp_ecp_pkg::P_EPPSTB);
  assign hostBusy = eppActive || r.rdStage;
  assign take = (hostWr || hostRd) && !hostBusy;
  assign eppMode = (r.mode == epp_ecp_pkg::MODE_ENHANCED) && eppEnable;
  assign eppStart = take && !dmaAck && eppMode && (offset >= epp_ecp_pkg::OFF_EPP_ADDR)
    && (offset <= epp_ecp_pkg::OFF_EPP_DATA_HI);
  // direction ignored in standard and compatibility FIFO modes
  assign dirEff = r.ctl[epp_ecp_pkg::CTL_DIR_BIT] && (r.mode != epp_ecp_pkg::MODE_STD)
    && (r.mode != epp_ecp_pkg::MODE_COMPAT_FIFO);
  assign fwdEngine = (r.mode == epp_ecp_pkg::MODE_COMPAT_FIFO)
    || ((r.mode == epp_ecp_pkg::MODE_EXTENDED) && !dirEff);
  assign revEngine = (r.mode == epp_ecp_pkg::MODE_EXTENDED) && dirEff;
  assign hostFifoWr = fwdEngine || (r.mode == epp_ecp_pkg::MODE_TEST);
  assign hostFifoRd = revEngine || (r.mode == epp_ecp_pkg::MODE_TEST);
  // dma stops while the service bit is set
  assign dmaReq = r.dmaEn && !r.svcIntr
    && ((hostFifoWr && !fifoFull) || (hostFifoRd && !fifoEmpty));

  always_comb
  begin
    n = r;
    fifoPush = 1'b0;
    fifoPushData = '0;
    fifoPop = 1'b0;
    n.rdValid = 1'b0;
    n.ackQ = acknowledgeInN;
    n.irq = r.ctl[epp_ecp_pkg::CTL_ACKIRQ_BIT] && acknowledgeInN && !r.ackQ;
    if (r.rdStage)
    begin
      n.rdStage = 1'b0;
      n.rdValid = 1'b1;
      case (r.rdSrc)
        3'h0: n.rdData = portLinesIn;
        3'h1: n.rdData = {!busyIn, acknowledgeInN, paperOutIn, selectedIn, faultInN,
          2'h3, eppMode ? r.tmo : 1'b1};
        3'h2: n.rdData = {2'h3, r.ctl};
        3'h4: n.rdData = (r.mode == epp_ecp_pkg::MODE_CONFIG) ?
          epp_ecp_pkg::CONFIG_A_VALUE : fifoRdData[7:0];
        3'h6: n.rdData = {r.mode, r.errIntrEn, r.dmaEn, r.svcIntr, fifoFull, fifoEmpty};
        default: n.rdData = 8'h00;
      endcase
    end
    if (take && dmaAck)
    begin
      if (hostWr && hostFifoWr && !fifoFull)
      begin
        fifoPush = 1'b1;
        fifoPushData = {1'b0, hostWrData};
      end
      if (hostRd)
      begin
        fifoPop = hostFifoRd && !fifoEmpty;
        n.rdStage = 1'b1;
        n.rdSrc = 3'h4;
      end
    end
    else if (take && hostWr && !eppStart)
    begin
      case (offset)
        epp_ecp_pkg::OFF_DATA:
          if (r.mode == epp_ecp_pkg::MODE_EXTENDED)
          begin
            // address/RLE tag rides in bit 8
            fifoPush = !dirEff && !fifoFull;
            fifoPushData = {1'b1, hostWrData};
          end
          else
            n.dataReg = hostWrData;
        epp_ecp_pkg::OFF_STATUS:
          if (hostWrData[epp_ecp_pkg::STAT_TMO_BIT])
            n.tmo = 1'b0;
        epp_ecp_pkg::OFF_CONTROL:
          n.ctl = hostWrData[5:0];
        epp_ecp_pkg::OFF_FIFO:
          if (hostFifoWr && !fifoFull)
          begin
            fifoPush = 1'b1;
            fifoPushData = {1'b0, hostWrData};
          end
        epp_ecp_pkg::OFF_EXT_CTRL:
        begin
          n.mode = hostWrData[7:epp_ecp_pkg::EXT_MODE_LSB];
          n.errIntrEn = hostWrData[epp_ecp_pkg::EXT_ERRINT_BIT];
          n.dmaEn = hostWrData[epp_ecp_pkg::EXT_DMA_BIT];
          n.svcIntr = hostWrData[epp_ecp_pkg::EXT_SVC_BIT];
        end
        default:
          n.dataReg = r.dataReg;
      endcase
    end
    else if (take && hostRd && !eppStart)
    begin
      n.rdStage = 1'b1;
      n.rdSrc = {offset[10], offset[1:0]};
      if ((offset == epp_ecp_pkg::OFF_FIFO) && hostFifoRd && !fifoEmpty)
        fifoPop = 1'b1;
      if ((offset > epp_ecp_pkg::OFF_EXT_CTRL)
        || ((offset > epp_ecp_pkg::OFF_CONTROL) && (offset < epp_ecp_pkg::OFF_FIFO)))
        n.rdSrc = 3'h7;
    end
    case (r.st)
      epp_ecp_pkg::P_IDLE:
        if (eppStart)
        begin
          n.isRead = hostRd;
          n.isAddr = (offset == epp_ecp_pkg::OFF_EPP_ADDR);
          n.outByte = hostWrData;
          n.cnt = '0;
          n.sawLow = !eppRev17;
          // 1.9 peripherals must show ready before the strobe
          n.st = (eppRev17 || !peripheralHoldN) ? epp_ecp_pkg::P_EPPSTB
            : epp_ecp_pkg::P_EPPWAIT;
        end
        else if (fwdEngine && !fifoEmpty)
        begin
          fifoPop = 1'b1;
          n.cnt = '0;
          n.st = epp_ecp_pkg::P_SETUP;
        end
        else if (revEngine && !fifoFull)
          n.st = epp_ecp_pkg::P_RREQ;
      epp_ecp_pkg::P_EPPWAIT, epp_ecp_pkg::P_EPPSTB:
      begin
        n.cnt = r.cnt + 8'h01;
        if (r.st == epp_ecp_pkg::P_EPPWAIT && !peripheralHoldN)
          n.st = epp_ecp_pkg::P_EPPSTB;
        if (!peripheralHoldN)
          n.sawLow = 1'b1;
        if ((r.st == epp_ecp_pkg::P_EPPSTB) && r.sawLow && peripheralHoldN)
        begin
          n.st = epp_ecp_pkg::P_IDLE;
          n.rdData = portLinesIn;
          n.rdValid = r.isRead;
        end
        else if (r.cnt == TMO_LAST)
        begin
          n.st = epp_ecp_pkg::P_IDLE;
          n.rdData = portLinesIn;
          n.rdValid = r.isRead;
          n.tmo = 1'b1;
        end
      end
      epp_ecp_pkg::P_SETUP:
      begin
        if (r.cnt == 8'h00)
        begin
          n.outByte = fifoRdData[7:0];
          n.outTag = fifoRdData[8];
        end
        if (r.cnt < STB_LAST)
          n.cnt = r.cnt + 8'h01;
        else if (!busyIn)
        begin
          n.cnt = '0;
          n.st = epp_ecp_pkg::P_STB;
        end
      end
      epp_ecp_pkg::P_STB:
      begin
        n.cnt = (r.cnt < STB_LAST) ? r.cnt + 8'h01 : r.cnt;
        if ((r.mode == epp_ecp_pkg::MODE_COMPAT_FIFO) ? (r.cnt == STB_LAST) : busyIn)
        begin
          n.cnt = '0;
          n.st = epp_ecp_pkg::P_HOLD;
        end
      end
      epp_ecp_pkg::P_HOLD:
      begin
        n.cnt = (r.cnt < STB_LAST) ? r.cnt + 8'h01 : r.cnt;
        if ((r.mode == epp_ecp_pkg::MODE_COMPAT_FIFO) ? (r.cnt == STB_LAST) : !busyIn)
          n.st = epp_ecp_pkg::P_IDLE;
      end
      epp_ecp_pkg::P_RREQ:
        if (!revEngine)
          n.st = epp_ecp_pkg::P_IDLE;
        else if (!acknowledgeInN)
        begin
          n.st = epp_ecp_pkg::P_RREL;
          if (!busyIn && !portLinesIn[7])
          begin
            n.rleCnt = portLinesIn;
            n.rlePend = 1'b1;
          end
          else if (busyIn && r.rlePend)
          begin
            n.outByte = portLinesIn;
            n.rlePend = 1'b0;
            n.st = epp_ecp_pkg::P_RLE;
          end
          else
          begin
            fifoPush = 1'b1;
            fifoPushData = {!busyIn, portLinesIn};
          end
        end
      epp_ecp_pkg::P_RLE:
        if (!fifoFull)
        begin
          // count plus one copies in total
          fifoPush = 1'b1;
          fifoPushData = {1'b0, r.outByte};
          n.rleCnt = r.rleCnt - 8'h01;
          if (r.rleCnt == 8'h00)
            n.st = epp_ecp_pkg::P_RREL;
        end
      epp_ecp_pkg::P_RREL:
        if (acknowledgeInN)
          n.st = epp_ecp_pkg::P_IDLE;
      default:
        n.st = epp_ecp_pkg::P_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      r <= RESET_STATE;
    else
      r <= n;
  end

  port_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .flush(r.mode == epp_ecp_pkg::MODE_STD),
    .push(fifoPush),
    .pushData(fifoPushData),
    .pop(fifoPop),
    .popData(fifoRdData),
    .full(fifoFull),
    .empty(fifoEmpty)
  );

  // pin multiplexing: enhanced strobes share the standard pins
  assign writeDirectionN = r.isRead;
  assign dataStrobeN = !((r.st == epp_ecp_pkg::P_EPPSTB) && !r.isAddr);
  assign addrStrobeN = !((r.st == epp_ecp_pkg::P_EPPSTB) && r.isAddr);
  assign fwdDrive = (r.st == epp_ecp_pkg::P_SETUP) || (r.st == epp_ecp_pkg::P_STB)
    || (r.st == epp_ecp_pkg::P_HOLD);

  always_comb
  begin
    portLinesOut = r.dataReg;
    portLinesOeN = dirEff;
    byteStrobeOutN = !r.ctl[epp_ecp_pkg::CTL_STROBE_BIT];
    autoLinefeedOutN = !r.ctl[epp_ecp_pkg::CTL_AUTOFD_BIT];
    selectRequestOutN = !r.ctl[epp_ecp_pkg::CTL_SELECT_BIT];
    if (eppActive)
    begin
      portLinesOut = r.outByte;
      portLinesOeN = r.isRead;
      byteStrobeOutN = writeDirectionN;
      autoLinefeedOutN = dataStrobeN;
      selectRequestOutN = addrStrobeN;
    end
    else if (fwdDrive)
    begin
      portLinesOut = r.outByte;
      portLinesOeN = 1'b0;
      byteStrobeOutN = (r.st != epp_ecp_pkg::P_STB);
      // extended mode marks address/RLE bytes by a low auto-feed
      if (r.mode == epp_ecp_pkg::MODE_EXTENDED)
        autoLinefeedOutN = !r.outTag;
    end
    else if ((r.st == epp_ecp_pkg::P_RREQ) || (r.st == epp_ecp_pkg::P_RLE))
      autoLinefeedOutN = 1'b0;
    else if (r.st == epp_ecp_pkg::P_RREL)
      autoLinefeedOutN = 1'b1;
  end

  assign peripheralReinitN = r.ctl[epp_ecp_pkg::CTL_INIT_BIT];
  assign hostRdData = r.rdData;
  assign hostRdValid = r.rdValid;
  assign ackIrq = r.irq;

  AST_TMO_ABORT: assert property (@(posedge clk) disable iff (rst)
    (eppActive && r.cnt == TMO_LAST && !(r.st == epp_ecp_pkg::P_EPPSTB && r.sawLow
    && peripheralHoldN)) |=> (r.st == epp_ecp_pkg::P_IDLE && r.tmo))
    else $error("enhanced cycle not aborted on time-out");
  AST_TMO_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (take && hostWr && !dmaAck && offset == epp_ecp_pkg::OFF_STATUS && hostWrData[0])
    |=> !r.tmo)
    else $error("time-out flag not cleared by writing one");
  AST_TMO_KEEP: assert property (@(posedge clk) disable iff (rst)
    (r.tmo && !(take && hostWr && offset == epp_ecp_pkg::OFF_STATUS && hostWrData[0]))
    |=> r.tmo)
    else $error("time-out flag lost without a clearing write");
  AST_EPP_STROBE: assert property (@(posedge clk) disable iff (rst)
    (r.st == epp_ecp_pkg::P_EPPSTB) |-> (byteStrobeOutN == r.isRead)
    && (autoLinefeedOutN == r.isAddr) && (selectRequestOutN == !r.isAddr))
    else $error("enhanced strobes wrong during cycle");
  AST_V19_HOLD: assert property (@(posedge clk) disable iff (rst)
    (eppStart && !eppRev17 && peripheralHoldN) |=> (r.st == epp_ecp_pkg::P_EPPWAIT)
    && autoLinefeedOutN && selectRequestOutN)
    else $error("cycle began while wait line high");
  AST_V17_END: assert property (@(posedge clk) disable iff (rst)
    (r.st == epp_ecp_pkg::P_EPPSTB && !r.sawLow && r.cnt != TMO_LAST)
    |=> (r.st == epp_ecp_pkg::P_EPPSTB))
    else $error("cycle ended without a low-to-high wait edge");
  AST_ACK_IRQ: assert property (@(posedge clk) disable iff (rst)
    ($rose(acknowledgeInN) && $past(r.ctl[epp_ecp_pkg::CTL_ACKIRQ_BIT]))
    |-> ##1 ackIrq)
    else $error("acknowledge edge raised no interrupt request");
  AST_DIR_FORCED: assert property (@(posedge clk) disable iff (rst)
    ((r.mode == epp_ecp_pkg::MODE_STD || r.mode == epp_ecp_pkg::MODE_COMPAT_FIFO)
    && !eppActive) |-> !portLinesOeN)
    else $error("port not driving in forced-output mode");
  AST_STATUS_READ: assert property (@(posedge clk) disable iff (rst)
    (take && hostRd && !dmaAck && offset == epp_ecp_pkg::OFF_STATUS) |-> ##2
    (hostRdValid && hostRdData[2:1] == 2'h3 && hostRdData[7] == !$past(busyIn)))
    else $error("status read value wrong");
  AST_CTL_READ: assert property (@(posedge clk) disable iff (rst)
    (take && hostRd && !dmaAck && offset == epp_ecp_pkg::OFF_CONTROL) |-> ##2
    (hostRdValid && hostRdData[7:6] == 2'h3))
    else $error("control bits 7 and 6 not read as one");
endmodule
`default_nettype wire

//--- test/epp_peripheral_model.sv
/*
  Enhanced-mode peripheral model for the parallel port bench.
  Assumes strobes and direction arrive on the multiplexed control pins.
*/
`timescale 1ns/10ps
`default_nettype none
module epp_peripheral_model (
  // clock, reset and knobs
  input wire logic clk,
  input wire logic rst,
  input wire logic mute,
  input wire logic [7:0] replyByte,
  // device pins
  input wire logic dataStrobeN,
  input wire logic addrStrobeN,
  input wire logic writeDirN,
  input wire logic [7:0] linesFromHost,
  output logic holdN,
  output logic [7:0] linesToHost,
  output logic [7:0] lastWritten
);
  logic [3:0] cnt;
  logic active;
  assign active = !dataStrobeN || !addrStrobeN;
  // released lines drift away from the reply so stale data never matches
  assign linesToHost = (active && writeDirN) ? replyByte : ~replyByte;
  always_ff @(posedge clk)
  begin
    if (rst || !active)
    begin
      holdN <= 1'b0;
      cnt <= 4'h0;
    end
    else if (!mute && cnt == 4'h3)
    begin
      holdN <= 1'b1;
      lastWritten <= writeDirN ? lastWritten : linesFromHost;
    end
    else
    begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- test/test_epp_ecp_parallel_port.sv
/*
  Self-checking bench for the parallel port: registers, pins, enhanced cycles.
  Assumes the peripheral model file is compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module test_epp_ecp_parallel_port;
  localparam logic [15:0] BASE = 16'h0378;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] hostAddr = 16'h0000;
  logic [7:0] hostWrData = 8'h00;
  logic hostWr = 1'b0;
  logic hostRd = 1'b0;
  logic eppRev17 = 1'b0;
  logic busyIn = 1'b1;
  logic ackN = 1'b0;
  logic paperOutIn = 1'b1;
  logic selectedIn = 1'b0;
  logic faultInN = 1'b1;
  logic mute = 1'b0;
  logic seen;
  logic dmaReq, gotAfd;
  logic [7:0] gotLines;
  logic [7:0] hostRdData, linesOut, linesIn, peerLines, lastWritten;
  logic hostRdValid, hostBusy, ackIrq, oeN, stbN, afdN, slinN, reinitN, holdN;
  int miscompares = 0;
  int tests_run = 0;
  int n;
  always #25 clk = ~clk;
  assign linesIn = oeN ? peerLines : linesOut;
  epp_ecp_parallel_port i_dut (.clk(clk), .rst(rst), .baseAddress(BASE), .hostAddr(hostAddr),
    .hostWrData(hostWrData), .hostWr(hostWr), .hostRd(hostRd), .hostRdData(hostRdData),
    .hostRdValid(hostRdValid), .hostBusy(hostBusy), .dmaAck(1'b0), .dmaReq(dmaReq), .ackIrq(ackIrq),
    .eppEnable(1'b1), .eppRev17(eppRev17), .busyIn(busyIn), .acknowledgeInN(ackN),
    .paperOutIn(paperOutIn), .selectedIn(selectedIn), .faultInN(faultInN),
    .peripheralHoldN(holdN), .portLinesIn(linesIn), .portLinesOut(linesOut), .portLinesOeN(oeN),
    .byteStrobeOutN(stbN), .autoLinefeedOutN(afdN), .selectRequestOutN(slinN),
    .peripheralReinitN(reinitN));
  epp_peripheral_model i_peer (.clk(clk), .rst(rst), .mute(mute), .replyByte(8'h3c),
    .dataStrobeN(afdN), .addrStrobeN(slinN), .writeDirN(stbN), .linesFromHost(linesOut),
    .holdN(holdN), .linesToHost(peerLines), .lastWritten(lastWritten));
  task automatic wrap_up;
  begin
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
  begin
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // each wait of this task is bounded; a hang ends the run as a mismatch
  task automatic waitFor(input logic busyWait);
  begin
    for (n = 0; n < 400 && (busyWait ? hostBusy !== 1'b0 : hostRdValid !== 1'b1); n++)
      @(negedge clk);
    if (n == 400)
    begin
      miscompares++;
      wrap_up();
    end
  end
  endtask
  task automatic wr(input logic [15:0] off, input logic [7:0] d);
  begin
    waitFor(1'b1);
    hostAddr = BASE + off;
    hostWrData = d;
    hostWr = 1'b1;
    @(negedge clk);
    hostWr = 1'b0;
    @(negedge clk);
  end
  endtask
  task automatic rdChk(input logic [15:0] off, input logic [7:0] exp);
  begin
    waitFor(1'b1);
    hostAddr = BASE + off;
    hostRd = 1'b1;
    @(negedge clk);
    hostRd = 1'b0;
    waitFor(1'b0);
    chk(hostRdData, exp);
    @(negedge clk);
  end
  endtask
  // acts as printer: catches the strobed byte, answers with busy
  task automatic fifoOut(output logic [7:0] d, output logic a);
  begin
    for (n = 0; n < 100 && stbN !== 1'b0; n++)
      @(negedge clk);
    if (n == 100)
      miscompares++;
    d = linesOut;
    a = afdN;
    busyIn = 1'b1;
    for (n = 0; n < 100 && stbN !== 1'b1; n++)
      @(negedge clk);
    if (n == 100)
      miscompares++;
    busyIn = 1'b0;
  end
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    rdChk(16'h0002, 8'hc4);
    chk({4'h0, stbN, afdN, slinN, reinitN}, 8'h0f);
    wr(16'h0002, 8'h0b);
    chk({4'h0, stbN, afdN, slinN, reinitN}, 8'h00);
    rdChk(16'h0002, 8'hcb);
    rdChk(16'h0001, 8'h2f);
    rdChk(16'h0402, 8'h15);
    wr(16'h0000, 8'ha5);
    wr(16'h0002, 8'h24);
    chk(linesOut, 8'ha5);
    chk({7'h0, oeN}, 8'h00);
    rdChk(16'h0000, 8'ha5);
    wr(16'h0402, 8'h34);
    chk({7'h0, oeN}, 8'h01);
    rdChk(16'h0000, 8'hc3);
    wr(16'h0002, 8'h14);
    busyIn = 1'b0;
    selectedIn = 1'b1;
    paperOutIn = 1'b0;
    faultInN = 1'b0;
    ackN = 1'b1;
    seen = 1'b0;
    repeat (8)
    begin
      @(negedge clk);
      seen = seen | ackIrq;
    end
    chk({7'h0, seen}, 8'h01);
    wr(16'h0002, 8'h04);
    wr(16'h0402, 8'hd5);
    rdChk(16'h0402, 8'hd5);
    wr(16'h0400, 8'h11);
    rdChk(16'h0402, 8'hd4);
    rdChk(16'h0400, 8'h11);
    wr(16'h0402, 8'h94);
    wr(16'h0004, 8'h5a);
    chk({4'h0, afdN, stbN, slinN, oeN}, 8'h02);
    waitFor(1'b1);
    chk(lastWritten, 8'h5a);
    chk({4'h0, afdN, stbN, slinN, oeN}, 8'h0e);
    wr(16'h0003, 8'h17);
    chk({4'h0, afdN, stbN, slinN, oeN}, 8'h08);
    waitFor(1'b1);
    chk(lastWritten, 8'h17);
    rdChk(16'h0003, 8'h3c);
    rdChk(16'h0004, 8'h3c);
    rdChk(16'h0001, 8'hd6);
    mute = 1'b1;
    wr(16'h0004, 8'h99);
    waitFor(1'b1);
    // cycle already ran one cycle inside the write task
    chk({7'h0, n >= 195 && n <= 200}, 8'h01);
    mute = 1'b0;
    rdChk(16'h0001, 8'hd7);
    wr(16'h0001, 8'h00);
    rdChk(16'h0001, 8'hd7);
    wr(16'h0001, 8'h01);
    rdChk(16'h0001, 8'hd6);
    eppRev17 = 1'b1;
    wr(16'h0004, 8'h42);
    waitFor(1'b1);
    chk(lastWritten, 8'h42);
    eppRev17 = 1'b0;
    wr(16'h0402, 8'h58);
    chk({7'h0, dmaReq}, 8'h01);
    wr(16'h0400, 8'h66);
    fifoOut(gotLines, gotAfd);
    chk(gotLines, 8'h66);
    wr(16'h0402, 8'h74);
    wr(16'h0000, 8'h22);
    fifoOut(gotLines, gotAfd);
    chk(gotLines, 8'h22);
    chk({7'h0, gotAfd}, 8'h00);
    wr(16'h0400, 8'h33);
    fifoOut(gotLines, gotAfd);
    chk(gotLines, 8'h33);
    chk({7'h0, gotAfd}, 8'h01);
    wrap_up();
  end
endmodule
`default_nettype wire
